// ==== hw/sbc_irq_pkg.sv ====
// Constants shared by the interrupt mask and fault-flag block.
// Assumes a 40 MHz ref_clk and 7-bit register addresses.
`default_nettype none

package sbc_irq_pkg;

    // Register addresses
    localparam logic [6:0] ADDR_GLOBAL_SUMMARY = 7'h50;
    localparam logic [6:0] ADDR_WAKE_WD_FLAGS = 7'h51;
    localparam logic [6:0] ADDR_WAKE_WD_MASK = 7'h56;
    localparam logic [6:0] ADDR_SUPPLY_MASK = 7'h57;
    localparam logic [6:0] ADDR_SERIAL_MASK = 7'h58;
    localparam logic [6:0] ADDR_LIN_FLAGS = 7'h5A;
    localparam logic [6:0] ADDR_LIN_MASK = 7'h5E;
    localparam logic [6:0] ADDR_MAP_TOP = 7'h7F;

    // Field positions, wake and watchdog group
    localparam int WD_EVENT_POS = 7;
    localparam int LOCAL_WAKE_POS = 5;
    localparam int WAKE_ERROR_POS = 4;
    // Field positions, supply and thermal group
    localparam int REG_OV_POS = 5;
    localparam int SUP_UV_POS = 4;
    localparam int REG_UV_POS = 2;
    localparam int THERM_REG_BUS_POS = 1;
    localparam int THERM_SWITCH_POS = 0;
    // Field positions, serial and fail-safe group
    localparam int SERIAL_ERR_POS = 7;
    localparam int FAILSAFE_POS = 5;
    localparam int CHECKSUM_POS = 4;
    localparam int REG_SHORT_POS = 3;
    localparam int RESTART_POS = 2;
    // Field positions, bus and switch group
    localparam int BUS_WAKE_POS = 7;
    localparam int BUS_TIMEOUT_POS = 6;
    localparam int SW_OVERCURRENT_POS = 3;
    localparam int SW_OPEN_LOAD_POS = 2;
    // Field positions, global summary
    localparam int SUM_ANY_POS = 7;
    localparam int SUM_GROUP1_POS = 6;
    localparam int SUM_GROUP2_POS = 5;
    localparam int SUM_GROUP3_POS = 4;
    localparam int SUM_GROUP4_POS = 2;

    // Reset values
    localparam logic [7:0] RST_WAKE_WD_MASK = 8'hB0;
    localparam logic [7:0] RST_SUPPLY_MASK = 8'h37;
    localparam logic [7:0] RST_SERIAL_MASK = 8'hBC;
    localparam logic [7:0] RST_LIN_FLAGS = 8'h00;
    localparam logic [7:0] RST_LIN_MASK = 8'hCC;

    // Serial frame: 7 address bits, write flag, 8 data bits
    localparam int FRAME_BITS = 16;
    localparam int HEADER_BITS = 8;

    // Normal-mode entry settling time
    localparam int CLK_PERIOD_NS = 25;
    localparam int NORMAL_INIT_NS = 20000;
    localparam int NORMAL_INIT_CYCLES =
        (NORMAL_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_CNT_W = $clog2(NORMAL_INIT_CYCLES + 1);

endpackage : sbc_irq_pkg

`default_nettype wire

// ==== hw/spi_reg_if.sv ====
// Register access channel between serial front end and register file.
// Assumes both ends run on ref_clk; strobes are one-cycle pulses.
`default_nettype none

interface spi_reg_if;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic wrStrobe;
    logic rdStrobe;

    modport frontEnd (output addr, wdata, wrStrobe, rdStrobe, input rdata);
    modport regFile (input addr, wdata, wrStrobe, rdStrobe, output rdata);
endinterface : spi_reg_if

`default_nettype wire

// ==== hw/spi_frame_slave.sv ====
// Serial register port: samples the link pins on ref_clk.
// Assumes link clock idle low, data sampled on its rising edge.
`default_nettype none

module spi_frame_slave
    import sbc_irq_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Serial pins
    input wire logic sclkPin,
    input wire logic csNPin,
    input wire logic sdiPin,
    output logic sdoOut,
    output logic sdoOe,
    output logic frameError,
    // Register side
    spi_reg_if.frontEnd bus
);
    logic sclkS1, sclkS2, sclkPrev_q, csS1, csS2, csPrev_q, sdiS1, sdiS2;
    logic [4:0] bitCnt_q;
    logic [7:0] shiftIn_q, shiftOut_q;
    logic isWrite_q, sclkRise, sclkFall, active;

    // Two-stage synchronisers; only stage two feeds logic
    always_ff @(posedge ref_clk)
    begin
        sclkS1 <= sclkPin;
        sclkS2 <= sclkS1;
        csS1 <= csNPin;
        csS2 <= csS1;
        sdiS1 <= sdiPin;
        sdiS2 <= sdiS1;
        sclkPrev_q <= sclkS2;
        csPrev_q <= csS2;
    end

    assign active = !csS2;
    assign sclkRise = active && sclkS2 && !sclkPrev_q;
    assign sclkFall = active && !sclkS2 && sclkPrev_q;

    // Bit counter saturates so an overlong frame stays detectable
    always_ff @(posedge ref_clk)
    begin
        if (reset || !active)
            bitCnt_q <= 5'h00;
        else if (sclkRise && bitCnt_q != 5'h11)
            bitCnt_q <= bitCnt_q + 5'h01;
    end

    // Header and data capture, strobes to the register file
    always_ff @(posedge ref_clk)
    begin
        bus.rdStrobe <= 1'b0;
        bus.wrStrobe <= 1'b0;
        if (reset)
        begin
            shiftIn_q <= 8'h00;
            isWrite_q <= 1'b0;
            bus.addr <= 7'h00;
            bus.wdata <= 8'h00;
        end
        else if (sclkRise)
        begin
            shiftIn_q <= {shiftIn_q[6:0], sdiS2};
            if (bitCnt_q == 5'(HEADER_BITS - 1))
            begin
                bus.addr <= shiftIn_q[6:0];
                isWrite_q <= sdiS2;
                bus.rdStrobe <= 1'b1;
            end
            if (bitCnt_q == 5'(FRAME_BITS - 1))
            begin
                bus.wdata <= {shiftIn_q[6:0], sdiS2};
                bus.wrStrobe <= isWrite_q;
            end
        end
    end

    // Read data loads after the header, shifts on falling edges
    always_ff @(posedge ref_clk)
    begin
        if (reset || !active)
            shiftOut_q <= 8'h00;
        else if (bus.rdStrobe)
            shiftOut_q <= bus.rdata;
        else if (sclkFall && bitCnt_q > 5'(HEADER_BITS))
            shiftOut_q <= {shiftOut_q[6:0], 1'b0};
    end

    // Short or long frame flagged when chip select rises
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            frameError <= 1'b0;
        else
            frameError <= csS2 && !csPrev_q && bitCnt_q != 5'h00
                && bitCnt_q != 5'(FRAME_BITS);
    end

    assign sdoOut = shiftOut_q[7];
    assign sdoOe = active;

endmodule : spi_frame_slave

`default_nettype wire

// ==== hw/mode_supervisor.sv ====
// Supply watch, receive-pin standby signalling and normal-entry settling.
// Assumes supply comparators and receiver output are asynchronous pins.
`default_nettype none

module mode_supervisor
    import sbc_irq_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Analog and receiver pins
    input wire logic supplyUvPin,
    input wire logic porBelowPin,
    input wire logic busRxdPin,
    // Mode control
    input wire logic normalEntryReq,
    output logic rxdOut,
    output logic porReset,
    output logic standbyActive,
    output logic normalReady
);
    logic uvS1, uvS2, porS1, porS2, rxS1, rxS2;
    logic [INIT_CNT_W-1:0] initCnt_q;

    // Synchronisers for the comparator and receiver pins
    always_ff @(posedge ref_clk)
    begin
        uvS1 <= supplyUvPin;
        uvS2 <= uvS1;
        porS1 <= porBelowPin;
        porS2 <= porS1;
        rxS1 <= busRxdPin;
        rxS2 <= rxS1;
    end

    // Only a fall below the threshold resets; a brownout passes
    assign porReset = porS2;
    assign standbyActive = uvS2;

    // Undervoltage pulls receive output low to flag standby
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            rxdOut <= 1'b1;
        else
            rxdOut <= uvS2 ? 1'b0 : rxS2;
    end

    // Every normal entry restarts the settling count
    always_ff @(posedge ref_clk)
    begin
        if (reset || porS2)
        begin
            initCnt_q <= '0;
            normalReady <= 1'b0;
        end
        else if (normalEntryReq)
        begin
            initCnt_q <= INIT_CNT_W'(NORMAL_INIT_CYCLES);
            normalReady <= 1'b0;
        end
        else if (initCnt_q != '0)
        begin
            initCnt_q <= initCnt_q - 1'b1;
            normalReady <= (initCnt_q == INIT_CNT_W'(1));
        end
    end

    property p_standby_rxd;
        @(posedge ref_clk) disable iff (reset)
        uvS2 |=> !rxdOut;
    endproperty
    a_standby_rxd: assert property (p_standby_rxd)
        else $error("receive output not low during undervoltage");

    property p_init_hold;
        @(posedge ref_clk) disable iff (reset || porS2)
        normalEntryReq |=> !normalReady [*8];
    endproperty
    a_init_hold: assert property (p_init_hold)
        else $error("normal ready before settling interval");

endmodule : mode_supervisor

`default_nettype wire

// ==== hw/sbc_interrupt_mask_flags.sv ====
// Interrupt enable registers, bus and switch fault flags, summary and
// interrupt pin. Assumes flag groups 1 to 3 are kept by other logic on
// ref_clk and that event inputs are single-cycle pulses on ref_clk.
`default_nettype none

module sbc_interrupt_mask_flags
    import sbc_irq_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Serial register pins
    input wire logic sclkPin,
    input wire logic csNPin,
    input wire logic sdiPin,
    output logic sdoOut,
    output logic sdoOe,
    output logic serialFrameError,
    // Flag groups kept elsewhere
    input wire logic [7:0] flagGroup1,
    input wire logic [7:0] flagGroup2,
    input wire logic [7:0] flagGroup3,
    // Wake error sources
    input wire logic wakeTimerExpired,
    input wire logic sleepModeActive,
    // Bus and switch fault events
    input wire logic busWakeEvent,
    input wire logic busTimeoutEvent,
    input wire logic switchOvercurrentEvent,
    input wire logic switchOpenLoadEvent,
    // Supply and receive pins
    input wire logic supplyUvPin,
    input wire logic porBelowPin,
    input wire logic busRxdPin,
    output logic rxdOut,
    output logic standbyActive,
    // Mode control
    input wire logic normalEntryReq,
    output logic normalReady,
    // Interrupt pin
    output logic interruptRequestOutN
);
    // Writable bits of each enable register
    localparam logic [7:0] WAKE_WD_RW = (8'h01 << WD_EVENT_POS)
        | (8'h01 << LOCAL_WAKE_POS) | (8'h01 << WAKE_ERROR_POS);
    localparam logic [7:0] SUPPLY_RW = (8'h01 << REG_OV_POS)
        | (8'h01 << SUP_UV_POS) | (8'h01 << REG_UV_POS)
        | (8'h01 << THERM_REG_BUS_POS) | (8'h01 << THERM_SWITCH_POS);
    localparam logic [7:0] SERIAL_RW = (8'h01 << SERIAL_ERR_POS)
        | (8'h01 << FAILSAFE_POS) | (8'h01 << CHECKSUM_POS)
        | (8'h01 << REG_SHORT_POS) | (8'h01 << RESTART_POS);
    localparam logic [7:0] LIN_RW = (8'h01 << BUS_WAKE_POS)
        | (8'h01 << BUS_TIMEOUT_POS) | (8'h01 << SW_OVERCURRENT_POS)
        | (8'h01 << SW_OPEN_LOAD_POS);

    spi_reg_if regBus ();

    logic porReset, regReset;
    logic [7:0] wakeWdMask_q, supplyMask_q, serialMask_q, linMask_q;
    logic [7:0] linFlags_q, linFlags_d, linSet, linClr;
    logic wakeErrorFlag_q, wakeErrorFlag_d, wakeErrSet, wakeErrClr;
    logic [7:0] group1View, summary, readData;
    logic anyEnabled, irq_q;

    // Flag update with set winning over a same-cycle clear
    function automatic logic [7:0] w1cNext(
        input logic [7:0] cur,
        input logic [7:0] set,
        input logic [7:0] clr
    );
        w1cNext = (cur & ~clr) | set;
    endfunction : w1cNext

    // True when a write strobe targets the given address
    function automatic logic writeHit(
        input logic strobe,
        input logic [6:0] addr,
        input logic [6:0] target
    );
        writeHit = strobe && (addr == target);
    endfunction : writeHit

    // Serial front end
    spi_frame_slave u_spi (
        .ref_clk (ref_clk),
        .reset (reset),
        .sclkPin (sclkPin),
        .csNPin (csNPin),
        .sdiPin (sdiPin),
        .sdoOut (sdoOut),
        .sdoOe (sdoOe),
        .frameError (serialFrameError),
        .bus (regBus.frontEnd)
    );

    // Supply watch and receive-pin handling
    mode_supervisor u_mode (
        .ref_clk (ref_clk),
        .reset (reset),
        .supplyUvPin (supplyUvPin),
        .porBelowPin (porBelowPin),
        .busRxdPin (busRxdPin),
        .normalEntryReq (normalEntryReq),
        .rxdOut (rxdOut),
        .porReset (porReset),
        .standbyActive (standbyActive),
        .normalReady (normalReady)
    );

    // Supply below threshold returns every register to its default
    assign regReset = reset || porReset;

    // Wake and watchdog enables; reserved bits never stored
    always_ff @(posedge ref_clk)
    begin
        if (regReset)
            wakeWdMask_q <= RST_WAKE_WD_MASK;
        else if (writeHit(regBus.wrStrobe, regBus.addr, ADDR_WAKE_WD_MASK))
            wakeWdMask_q <= regBus.wdata & WAKE_WD_RW;
    end

    // Supply, regulator and thermal enables
    always_ff @(posedge ref_clk)
    begin
        if (regReset)
            supplyMask_q <= RST_SUPPLY_MASK;
        else if (writeHit(regBus.wrStrobe, regBus.addr, ADDR_SUPPLY_MASK))
            supplyMask_q <= regBus.wdata & SUPPLY_RW;
    end

    // Serial, fail-safe, short and restart enables
    always_ff @(posedge ref_clk)
    begin
        if (regReset)
            serialMask_q <= RST_SERIAL_MASK;
        else if (writeHit(regBus.wrStrobe, regBus.addr, ADDR_SERIAL_MASK))
            serialMask_q <= regBus.wdata & SERIAL_RW;
    end

    // Bus and switch fault enables
    always_ff @(posedge ref_clk)
    begin
        if (regReset)
            linMask_q <= RST_LIN_MASK;
        else if (writeHit(regBus.wrStrobe, regBus.addr, ADDR_LIN_MASK))
            linMask_q <= regBus.wdata & LIN_RW;
    end

    // Bus and switch fault flag sources and clears
    always_comb
    begin
        linSet = 8'h00;
        linSet[BUS_WAKE_POS] = busWakeEvent;
        linSet[BUS_TIMEOUT_POS] = busTimeoutEvent;
        linSet[SW_OVERCURRENT_POS] = switchOvercurrentEvent;
        linSet[SW_OPEN_LOAD_POS] = switchOpenLoadEvent;
        linClr = 8'h00;
        if (writeHit(regBus.wrStrobe, regBus.addr, ADDR_LIN_FLAGS))
            linClr = regBus.wdata & LIN_RW;
        linFlags_d = w1cNext(linFlags_q, linSet, linClr) & LIN_RW;
    end

    // Flags hold until software writes a one to them
    always_ff @(posedge ref_clk)
    begin
        if (regReset)
            linFlags_q <= RST_LIN_FLAGS;
        else
            linFlags_q <= linFlags_d;
    end

    // Wake error: timer expired after falling back to sleep
    always_comb
    begin
        wakeErrSet = wakeTimerExpired && sleepModeActive;
        wakeErrClr = writeHit(regBus.wrStrobe, regBus.addr,
            ADDR_WAKE_WD_FLAGS) && regBus.wdata[WAKE_ERROR_POS];
        // Set wins over a clear written in the same cycle
        wakeErrorFlag_d = (wakeErrorFlag_q && !wakeErrClr) || wakeErrSet;
    end

    always_ff @(posedge ref_clk)
    begin
        if (regReset)
            wakeErrorFlag_q <= 1'b0;
        else
            wakeErrorFlag_q <= wakeErrorFlag_d;
    end

    // Group 1 as seen by software carries the local wake error flag
    always_comb
    begin
        group1View = flagGroup1;
        group1View[WAKE_ERROR_POS] = wakeErrorFlag_q;
    end

    // Summary: raw OR of all flags, and one bit per group
    always_comb
    begin
        summary = 8'h00;
        summary[SUM_GROUP1_POS] = |group1View;
        summary[SUM_GROUP2_POS] = |flagGroup2;
        summary[SUM_GROUP3_POS] = |flagGroup3;
        summary[SUM_GROUP4_POS] = |linFlags_q;
        summary[SUM_ANY_POS] = |summary;
    end

    // Read decode; anything else up to the map top reads zero
    always_comb
    begin
        unique case (regBus.addr)
            ADDR_GLOBAL_SUMMARY: readData = summary;
            ADDR_WAKE_WD_FLAGS: readData = group1View;
            ADDR_WAKE_WD_MASK: readData = wakeWdMask_q;
            ADDR_SUPPLY_MASK: readData = supplyMask_q;
            ADDR_SERIAL_MASK: readData = serialMask_q;
            ADDR_LIN_FLAGS: readData = linFlags_q;
            ADDR_LIN_MASK: readData = linMask_q;
            default: readData = 8'h00;
        endcase
    end

    assign regBus.rdata = readData;

    // Any flag with its enable set pulls the pin low
    assign anyEnabled = |(group1View & wakeWdMask_q)
        || |(flagGroup2 & supplyMask_q)
        || |(flagGroup3 & serialMask_q)
        || |(linFlags_q & linMask_q);

    // Registered so the pin never glitches on decode
    always_ff @(posedge ref_clk)
    begin
        if (regReset)
            irq_q <= 1'b0;
        else
            irq_q <= anyEnabled;
    end

    assign interruptRequestOutN = !irq_q;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (regReset);

    sequence s_enabled_watchdog;
        group1View[WD_EVENT_POS] && wakeWdMask_q[WD_EVENT_POS];
    endsequence

    sequence s_all_quiet;
        !anyEnabled [*2];
    endsequence

    property p_watchdog_gate;
        s_enabled_watchdog |=> !interruptRequestOutN;
    endproperty
    a_watchdog_gate: assert property (p_watchdog_gate)
        else $error("enabled watchdog flag did not raise interrupt");

    property p_pin_release;
        s_all_quiet |-> interruptRequestOutN;
    endproperty
    a_pin_release: assert property (p_pin_release)
        else $error("interrupt held with no enabled flag");

    property p_mask1_write;
        writeHit(regBus.wrStrobe, regBus.addr, ADDR_WAKE_WD_MASK)
        |=> wakeWdMask_q == ($past(regBus.wdata) & WAKE_WD_RW);
    endproperty
    a_mask1_write: assert property (p_mask1_write)
        else $error("wake and watchdog enable write wrong");

    property p_mask3_write;
        writeHit(regBus.wrStrobe, regBus.addr, ADDR_SERIAL_MASK)
        |=> serialMask_q == ($past(regBus.wdata) & SERIAL_RW);
    endproperty
    a_mask3_write: assert property (p_mask3_write)
        else $error("serial enable write wrong");

    property p_flag_set_wins;
        busWakeEvent |=> linFlags_q[BUS_WAKE_POS];
    endproperty
    a_flag_set_wins: assert property (p_flag_set_wins)
        else $error("bus wake event lost");

    property p_flag_clear;
        writeHit(regBus.wrStrobe, regBus.addr, ADDR_LIN_FLAGS)
        && regBus.wdata[SW_OVERCURRENT_POS] && !switchOvercurrentEvent
        |=> !linFlags_q[SW_OVERCURRENT_POS];
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("overcurrent flag not cleared by write one");

    property p_lin_mask_reserved;
        writeHit(regBus.wrStrobe, regBus.addr, ADDR_LIN_MASK)
        |=> (linMask_q & ~LIN_RW) == 8'h00 ##1 linMask_q == $past(linMask_q);
    endproperty
    a_lin_mask_reserved: assert property (p_lin_mask_reserved)
        else $error("reserved enable bits stored");

    property p_reserved_read;
        regBus.rdStrobe && regBus.addr > ADDR_LIN_MASK |-> readData == 8'h00;
    endproperty
    a_reserved_read: assert property (p_reserved_read)
        else $error("reserved address read nonzero");

    property p_summary_any;
        linFlags_q != 8'h00 |-> summary[SUM_ANY_POS] && summary[SUM_GROUP4_POS];
    endproperty
    a_summary_any: assert property (p_summary_any)
        else $error("summary does not reflect fault flags");

    property p_wake_error_set;
        wakeTimerExpired && sleepModeActive |=> wakeErrorFlag_q;
    endproperty
    a_wake_error_set: assert property (p_wake_error_set)
        else $error("wake error flag not set");

    property p_por_defaults;
        @(posedge ref_clk) disable iff (reset)
        porReset |=> wakeWdMask_q == RST_WAKE_WD_MASK
            && linMask_q == RST_LIN_MASK && linFlags_q == RST_LIN_FLAGS;
    endproperty
    a_por_defaults: assert property (p_por_defaults)
        else $error("registers not at defaults after supply reset");

endmodule : sbc_interrupt_mask_flags

`default_nettype wire

// ==== hw/README_unused.sv ====
`default_nettype none
`default_nettype wire

// ==== verification/spi_host_model.sv ====
// Host side serial master, mode 0 frames of 16 bits.
// Assumes the device samples these pins on ref_clk.
`default_nettype none

module spi_host_model (
    // Clock
    input wire logic ref_clk,
    // Serial pins
    input wire logic sdoOut,
    output logic sclkPin,
    output logic csNPin,
    output logic sdiPin
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle pins; link clock stands low outside frames
    initial
    begin
        sclkPin = 1'b0;
        csNPin = 1'b1;
        sdiPin = 1'b0;
    end

    // Whole frame; read data taken at each of the last 8 rises
    task automatic xfer(input logic [15:0] frm, output logic [7:0] rd);
        @(negedge ref_clk) csNPin = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            sdiPin = frm[i];
            repeat (4) @(negedge ref_clk);
            sclkPin = 1'b1;
            if (i < 8)
                rd[i] = sdoOut;
            repeat (4) @(negedge ref_clk);
            sclkPin = 1'b0;
        end
        repeat (4) @(negedge ref_clk);
        csNPin = 1'b1;
        // Released line shows the inverse, never a stale bit
        sdiPin = ~sdiPin;
        repeat (6) @(negedge ref_clk);
    endtask : xfer

    // Frame cut after n link clocks; no write may land
    task automatic cut(input int n);
        @(negedge ref_clk) csNPin = 1'b0;
        repeat (n)
        begin
            repeat (4) @(negedge ref_clk);
            sclkPin = 1'b1;
            repeat (4) @(negedge ref_clk);
            sclkPin = 1'b0;
        end
        repeat (4) @(negedge ref_clk);
        csNPin = 1'b1;
        repeat (6) @(negedge ref_clk);
    endtask : cut
endmodule : spi_host_model

`default_nettype wire

// ==== verification/sbc_interrupt_mask_flags_test.sv ====
// Bench for interrupt masks, fault flags and mode pins.
// Assumes the host model owns the serial pins.
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin \
    num_errors++; $display("ERROR %s exp %h got %h", n, e, a); end end

module sbc_interrupt_mask_flags_test import sbc_irq_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0, reset = 1'b1, sclk, csN, sdi, sdo;
    logic wt = 1'b0, uv = 1'b0, por = 1'b0, ne = 1'b0;
    logic sl = 1'b0, rx = 1'b1, oe, fe;
    logic rxdOut, sby, rdy, irqN;
    logic [3:0] ev = 4'h0;
    logic [3:0] feCnt = 4'h0;
    logic [7:0] g1 = 8'h00, g2 = 8'h00, g3 = 8'h00, rd, v;
    logic [7:0] mk [3];
    logic [6:0] ma [4] = '{ADDR_WAKE_WD_MASK, ADDR_SUPPLY_MASK,
        ADDR_SERIAL_MASK, ADDR_LIN_MASK};
    logic [7:0] mr [4] = '{RST_WAKE_WD_MASK, RST_SUPPLY_MASK,
        RST_SERIAL_MASK, RST_LIN_MASK};
    int num_errors = 0, comparisons = 0, seed = 1;

    sbc_interrupt_mask_flags i_sbc_interrupt_mask_flags (
        .ref_clk(ref_clk), .reset(reset), .sclkPin(sclk),
        .csNPin(csN), .sdiPin(sdi), .sdoOut(sdo), .sdoOe(oe),
        .serialFrameError(fe), .flagGroup1(g1), .flagGroup2(g2),
        .flagGroup3(g3), .wakeTimerExpired(wt), .sleepModeActive(sl),
        .busWakeEvent(ev[3]), .busTimeoutEvent(ev[2]),
        .switchOvercurrentEvent(ev[1]), .switchOpenLoadEvent(ev[0]),
        .supplyUvPin(uv), .porBelowPin(por), .busRxdPin(rx),
        .rxdOut(rxdOut), .standbyActive(sby), .normalEntryReq(ne),
        .normalReady(rdy), .interruptRequestOutN(irqN));
    spi_host_model host (.ref_clk(ref_clk), .sdoOut(sdo),
        .sclkPin(sclk), .csNPin(csN), .sdiPin(sdi));

    // Free running 40 MHz clock
    initial
    begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host.xfer({a, 1'b1, d}, rd);
    endtask : wr

    task automatic rdc(input logic [6:0] a, input logic [7:0] e);
        host.xfer({a, 1'b0, 8'h00}, rd);
        `CHK("reg", e, rd)
    endtask : rdc

    // One-cycle event, then room for flag and pin to settle
    task automatic pulse(input logic [3:0] e);
        @(negedge ref_clk) ev = e;
        @(negedge ref_clk) ev = 4'h0;
        repeat (3) @(negedge ref_clk);
    endtask : pulse

    // Expected pin: low while any enabled flag of groups 1 to 3, wake error bit aside, is up
    function automatic logic expIrqN(input logic [7:0] m1, m2, m3);
        return ((g1 & ~(8'h01 << WAKE_ERROR_POS) & m1) | (g2 & m2)
            | (g3 & m3)) == 8'h00;
    endfunction : expIrqN

    // Length error pulses counted off the sampling edge
    always @(negedge ref_clk)
    begin
        feCnt <= feCnt + {3'h0, fe};
    end

    task automatic summarize();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    // Hang guard, well beyond the expected run
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        summarize();
    end

    // Main sequence
    initial
    begin
        repeat (4) @(negedge ref_clk);
        reset = 1'b0;
        repeat (4) @(negedge ref_clk);
        `CHK("sdoOe", 1'b0, oe)
        rdc(ADDR_LIN_FLAGS, RST_LIN_FLAGS);
        for (int i = 0; i < 4; i++)
        begin
            rdc(ma[i], mr[i]);
            v = 8'($random(seed));
            wr(ma[i], v);
            rdc(ma[i], v & mr[i]);
            wr(ma[i], 8'hFF);
            rdc(ma[i], mr[i]);
        end
        wr(ADDR_MAP_TOP, 8'hFF);
        rdc(ADDR_MAP_TOP, 8'h00);
        // A cut frame is flagged once and writes nothing
        host.cut(12);
        `CHK("frameError", 4'h1, feCnt)
        pulse(4'hF);
        `CHK("irq", 1'b0, irqN)
        rdc(ADDR_LIN_FLAGS, 8'hCC);
        wr(ADDR_LIN_FLAGS, 8'h88);
        rdc(ADDR_LIN_FLAGS, 8'h44);
        wr(ADDR_LIN_FLAGS, 8'hFF);
        `CHK("irq", 1'b1, irqN)
        // Masked source must stay silent until enabled
        wr(ADDR_LIN_MASK, 8'h00);
        pulse(4'h8);
        `CHK("irq", 1'b1, irqN)
        wr(ADDR_LIN_MASK, 8'hFF);
        `CHK("irq", 1'b0, irqN)
        wr(ADDR_LIN_FLAGS, 8'h80);
        g2 = 8'h10;
        wr(ADDR_SUPPLY_MASK, 8'h00);
        `CHK("irq", 1'b1, irqN)
        wr(ADDR_SUPPLY_MASK, 8'h10);
        `CHK("irq", 1'b0, irqN)
        g2 = 8'h00;
        // Timer expiry outside sleep leaves the wake error clear
        @(negedge ref_clk) wt = 1'b1;
        @(negedge ref_clk) wt = 1'b0;
        rdc(ADDR_WAKE_WD_FLAGS, 8'h00);
        @(negedge ref_clk) {wt, sl} = 2'b11;
        @(negedge ref_clk) {wt, sl} = 2'b00;
        rdc(ADDR_WAKE_WD_FLAGS, 8'h10);
        wr(ADDR_WAKE_WD_FLAGS, 8'h10);
        rdc(ADDR_WAKE_WD_FLAGS, 8'h00);
        // Random flags against random enables
        for (int k = 0; k < 4; k++)
        begin
            for (int j = 0; j < 3; j++)
            begin
                v = 8'($random(seed));
                wr(ma[j], v);
                mk[j] = v & mr[j];
            end
            g1 = 8'($random(seed));
            g2 = 8'($random(seed));
            g3 = 8'($random(seed));
            repeat (3) @(negedge ref_clk);
            `CHK("irq", expIrqN(mk[0], mk[1], mk[2]), irqN)
        end
        // Watchdog event alone, enabled then masked
        wr(ma[0], 8'h80);
        g1 = 8'h80;
        g2 = 8'h00;
        g3 = 8'h00;
        repeat (3) @(negedge ref_clk);
        `CHK("irq", 1'b0, irqN)
        wr(ma[0], 8'h00);
        `CHK("irq", 1'b1, irqN)
        rdc(ADDR_GLOBAL_SUMMARY, 8'hC0);
        g1 = 8'h00;
        // Brownout: standby shown on receive pin, no reset
        uv = 1'b1;
        repeat (5) @(negedge ref_clk);
        `CHK("rxd", 1'b0, rxdOut)
        `CHK("standby", 1'b1, sby)
        uv = 1'b0;
        rdc(ma[0], 8'h00);
        `CHK("rxd", 1'b1, rxdOut)
        por = 1'b1;
        repeat (5) @(negedge ref_clk);
        por = 1'b0;
        repeat (6) @(negedge ref_clk);
        rdc(ma[0], mr[0]);
        // Receive edges during settling pass straight to the receive pin
        ne = 1'b1;
        @(negedge ref_clk) ne = 1'b0;
        rx = 1'b0;
        repeat (NORMAL_INIT_CYCLES - 1) @(negedge ref_clk);
        `CHK("ready", 1'b0, rdy)
        @(negedge ref_clk);
        `CHK("ready", 1'b1, rdy)
        `CHK("rxd", rx, rxdOut)
        summarize();
    end
endmodule : sbc_interrupt_mask_flags_test

`default_nettype wire
